// >>> rtl/tweep_defs.svh
// constants shared by both ends of the two-wire memory link
`ifndef TWEEP_DEFS_SVH
`define TWEEP_DEFS_SVH
`define TWE_DEV_PATTERN   4'hA
`define TWE_ADDR_BITS     15
`define TWE_PAGE_BITS     6
`define TWE_PAGE_BYTES    64
`define TWE_MEM_BYTES     32768
`define TWE_ACK_BIT       4'h8
`define TWE_LAST_BIT      4'h7
`define TWE_PROG_TIME_MS  5
`define TWE_REF_PERIOD_NS 100
`define TWE_PROG_CYCLES   (`TWE_PROG_TIME_MS * 1000000 / `TWE_REF_PERIOD_NS)
`define TWE_QTR_CYCLES    8'h19
`endif

// >>> rtl/tweep_pkg.sv
// types shared by both ends of the two-wire memory link
package tweep_pkg;
  typedef enum logic [4:0] {
    TD_DEV  = 5'h01,
    TD_AHI  = 5'h02,
    TD_ALO  = 5'h04,
    TD_DATA = 5'h08,
    TD_IGN  = 5'h10
  } tweep_dev_state_type;
  typedef enum logic [4:0] {
    TH_IDLE  = 5'h01,
    TH_START = 5'h02,
    TH_BYTE  = 5'h04,
    TH_FETCH = 5'h08,
    TH_STOP  = 5'h10
  } tweep_host_state_type;
  typedef enum logic [1:0] {
    TOP_WRITE   = 2'h0,
    TOP_POLL    = 2'h1,
    TOP_RECOVER = 2'h2
  } tweep_op_type;
endpackage : tweep_pkg

// >>> rtl/tweep_if.sv
// two-wire link between host controller and memory target
interface tweep_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // open drain: any enabled driver wins with its (low) level
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : tweep_if

// >>> rtl/tweep_target.sv
// memory target end: bit engine on the link clock, programming on ref_clk
`include "tweep_defs.svh"
module tweep_target import tweep_pkg::*; #(
  parameter int unsigned PROG_CYCLES = `TWE_PROG_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  tweep_if.dev             link,
  input  wire logic [2:0]  chip_select_straps,
  input  wire logic        write_protect,
  input  wire logic [14:0] peek_addr,
  output logic      [7:0]  peek_data,
  output logic             busy,
  output logic             standby
);

  ////////////////////////////////////////////////////////////////////////////
  // ref_clk domain: bus condition watch, frame reset, programming cycle
  logic [1:0]  scl_sy_q, scl_sy_d, sda_sy_q, sda_sy_d, wp_sy_q, wp_sy_d;
  logic [1:0]  gen_sy_q, gen_sy_d;
  logic        scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic        frm_rst_q, frm_rst_d, lnk_rst_q, lnk_rst_d;
  logic        busy_q, busy_d, idle_q, idle_d, stby_q, stby_d;
  logic        done_gen_q, done_gen_d, wp_lat_q, wp_lat_d;
  logic [31:0] timer_q, timer_d;
  logic [6:0]  idx_q, idx_d;
  logic [7:0]  peek_q;
  logic        start_w, stop_w;
  logic [7:0]  mem_q [0:`TWE_MEM_BYTES-1];

  // scl domain state, declared here because ref_clk reads the page buffer
  tweep_dev_state_type st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic        ack_q, ack_d, oe_q, oe_d;
  logic [1:0][2:0] strap_sy_q, strap_sy_d;
  logic [1:0]  bsy_sy_q, bsy_sy_d;
  logic [14:0] addr_q, addr_d;
  logic [63:0] mask_q, mask_d;
  logic        gen_q, gen_d, had_q, had_d;
  logic [7:0]  pbuf_q [0:`TWE_PAGE_BYTES-1];
  logic [7:0]  byte_w;
  logic        byte_end_w, dev_hit_w;

  assign start_w = scl_sy_q[1] & scl_p_q & sda_p_q & ~sda_sy_q[1];
  assign stop_w  = scl_sy_q[1] & scl_p_q & ~sda_p_q & sda_sy_q[1];

  always_comb begin
    scl_sy_d   = {scl_sy_q[0], link.scl};
    sda_sy_d   = {sda_sy_q[0], link.sda};
    wp_sy_d    = {wp_sy_q[0], write_protect};
    gen_sy_d   = {gen_sy_q[0], gen_q};
    scl_p_d    = scl_sy_q[1];
    sda_p_d    = sda_sy_q[1];
    lnk_rst_d  = 1'b0;
    // data moving under a high clock restarts the bit engine; held until clock falls
    frm_rst_d  = start_w | stop_w | (frm_rst_q & scl_sy_q[1]);
    idle_d     = stop_w ? 1'b1 : (start_w ? 1'b0 : idle_q);
    busy_d     = busy_q;
    done_gen_d = done_gen_q;
    wp_lat_d   = wp_lat_q;
    timer_d    = timer_q;
    idx_d      = idx_q;
    if (busy_q) begin
      timer_d = timer_q + 32'h1;
      if (!idx_q[6]) begin
        idx_d = 7'(idx_q + 7'h1);
      end
      if (timer_q == PROG_CYCLES - 1) begin
        busy_d = 1'b0;
      end
    end else if (stop_w && gen_sy_q[1] != done_gen_q) begin
      busy_d     = 1'b1;
      timer_d    = 32'h0;
      idx_d      = 7'h0;
      done_gen_d = gen_sy_q[1];
      wp_lat_d   = wp_sy_q[1];
    end
    stby_d = idle_d & ~busy_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_sy_q   <= 2'h3;
      sda_sy_q   <= 2'h3;
      wp_sy_q    <= 2'h0;
      gen_sy_q   <= 2'h0;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      frm_rst_q  <= 1'b1;
      lnk_rst_q  <= 1'b1;
      idle_q     <= 1'b1;
      busy_q     <= 1'b0;
      stby_q     <= 1'b1;
      done_gen_q <= 1'b0;
      wp_lat_q   <= 1'b0;
      timer_q    <= 32'h0;
      idx_q      <= 7'h40;
    end else begin
      scl_sy_q   <= scl_sy_d;
      sda_sy_q   <= sda_sy_d;
      wp_sy_q    <= wp_sy_d;
      gen_sy_q   <= gen_sy_d;
      scl_p_q    <= scl_p_d;
      sda_p_q    <= sda_p_d;
      frm_rst_q  <= frm_rst_d;
      lnk_rst_q  <= lnk_rst_d;
      idle_q     <= idle_d;
      busy_q     <= busy_d;
      stby_q     <= stby_d;
      done_gen_q <= done_gen_d;
      wp_lat_q   <= wp_lat_d;
      timer_q    <= timer_d;
      idx_q      <= idx_d;
    end
  end

  // page buffer is quiet after the stop: a new write is not acked while busy, so no data byte lands
  always_ff @(posedge ref_clk) begin
    if (busy_q && !idx_q[6] && mask_q[idx_q[5:0]] && !wp_lat_q) begin
      mem_q[{addr_q[14:6], idx_q[5:0]}] <= pbuf_q[idx_q[5:0]];
    end
    peek_q <= mem_q[peek_addr];
  end

  assign peek_data = peek_q;
  assign busy      = busy_q;
  assign standby   = stby_q;

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain: frame state, reset by every start and stop
  assign byte_w     = {sh_q[6:0], link.sda};
  assign byte_end_w = (bit_q == `TWE_LAST_BIT);
  assign dev_hit_w  = (byte_w[7:4] == `TWE_DEV_PATTERN)
                    && (byte_w[3:1] == strap_sy_q[1])
                    && !bsy_sy_q[1];

  always_comb begin
    st_d  = st_q;
    bit_d = (bit_q == `TWE_ACK_BIT) ? 4'h0 : 4'(bit_q + 4'h1);
    sh_d  = byte_w;
    ack_d = 1'b0;
    if (byte_end_w) begin
      unique case (st_q)
        TD_DEV: begin
          ack_d = dev_hit_w;
          // reads are acked but not served; the target then stays silent
          st_d  = (dev_hit_w && !byte_w[0]) ? TD_AHI : TD_IGN;
        end
        TD_AHI: begin
          ack_d = 1'b1;
          st_d  = TD_ALO;
        end
        TD_ALO: begin
          ack_d = 1'b1;
          st_d  = TD_DATA;
        end
        TD_DATA: begin
          ack_d = 1'b1;
        end
        TD_IGN: begin
          ack_d = 1'b0;
        end
      endcase
    end
    oe_d = (bit_q == `TWE_ACK_BIT) && ack_q;
  end

  always_ff @(posedge link.scl or posedge frm_rst_q) begin
    if (frm_rst_q) begin
      st_q  <= TD_DEV;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      ack_q <= ack_d;
    end
  end

  // ack drive changes on the falling clock so data is steady while high
  always_ff @(negedge link.scl or posedge frm_rst_q) begin
    if (frm_rst_q) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain: address, page buffer, write event toggle
  always_comb begin
    strap_sy_d = {strap_sy_q[0], chip_select_straps};
    bsy_sy_d   = {bsy_sy_q[0], busy_q};
    addr_d     = addr_q;
    mask_d     = mask_q;
    gen_d      = gen_q;
    had_d      = had_q;
    if (byte_end_w) begin
      unique case (st_q)
        TD_DEV: begin
          if (dev_hit_w && !byte_w[0]) begin
            mask_d = 64'h0;
            had_d  = 1'b0;
          end
        end
        TD_AHI: addr_d[14:8] = byte_w[6:0];
        TD_ALO: addr_d[7:0] = byte_w;
        TD_DATA: begin
          mask_d[addr_q[5:0]] = 1'b1;
          addr_d[5:0] = 6'(addr_q[5:0] + 6'h1);
          if (!had_q) begin
            gen_d = ~gen_q;
            had_d = 1'b1;
          end
        end
        TD_IGN: begin
        end
      endcase
    end
  end

  always_ff @(posedge link.scl or posedge lnk_rst_q) begin
    if (lnk_rst_q) begin
      strap_sy_q <= '0;
      bsy_sy_q   <= 2'h0;
      addr_q     <= 15'h0000;
      mask_q     <= 64'h0;
      gen_q      <= 1'b0;
      had_q      <= 1'b0;
    end else begin
      strap_sy_q <= strap_sy_d;
      bsy_sy_q   <= bsy_sy_d;
      addr_q     <= addr_d;
      mask_q     <= mask_d;
      gen_q      <= gen_d;
      had_q      <= had_d;
    end
  end

  always_ff @(posedge link.scl) begin
    if (byte_end_w && st_q == TD_DATA) begin
      pbuf_q[addr_q[5:0]] <= byte_w;
    end
  end

endmodule : tweep_target

// >>> rtl/tweep_host.sv
// host controller end: drives the link clock and issues writes, polls, recovery
`include "tweep_defs.svh"
module tweep_host import tweep_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  tweep_if.host            link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  tweep_op_type     cmd_op,
  input  wire logic [2:0]  cmd_sel,
  input  wire logic [14:0] cmd_addr,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_last,
  output logic             done,
  output logic             acked
);

  tweep_host_state_type st_q, st_d;
  tweep_op_type op_q, op_d;
  logic [1:0]  ph_q, ph_d, step_q, step_d, sda_sy_q, sda_sy_d;
  logic [7:0]  q_q, q_d, sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  sel_q, sel_d;
  logic [14:0] addr_q, addr_d;
  logic        last_q, last_d, rec_q, rec_d, ok_q, ok_d, nack_q, nack_d;
  logic        scl_q, scl_d, oe_q, oe_d, done_q, done_d, acked_q, acked_d;
  logic        tick_w, end_w;

  assign tick_w = (q_q == `TWE_QTR_CYCLES - 8'h01);
  assign end_w  = tick_w && (ph_q == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    ph_d    = tick_w ? 2'(ph_q + 2'h1) : ph_q;
    q_d     = tick_w ? 8'h00 : 8'(q_q + 8'h01);
    step_d  = step_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    sel_d   = sel_q;
    addr_d  = addr_q;
    last_d  = last_q;
    rec_d   = rec_q;
    ok_d    = ok_q;
    nack_d  = nack_q;
    sda_sy_d = {sda_sy_q[0], link.sda};
    done_d  = 1'b0;
    acked_d = acked_q;
    scl_d   = (ph_q == 2'h1) || (ph_q == 2'h2);
    oe_d    = 1'b0;
    unique case (st_q)
      TH_IDLE: begin
        scl_d = 1'b1;
        q_d   = 8'h00;
        ph_d  = 2'h0;
        if (cmd_valid) begin
          st_d   = TH_START;
          op_d   = cmd_op;
          sel_d  = cmd_sel;
          addr_d = cmd_addr;
          rec_d  = 1'b0;
          ok_d   = 1'b1;
          last_d = 1'b0;
        end
      end
      TH_START: begin
        // released data rises under low clock, then falls under high clock
        oe_d = ph_q[1];
        if (end_w) begin
          bit_d = 4'h0;
          if (op_q == TOP_RECOVER) begin
            rec_d = 1'b1;
            st_d  = rec_q ? TH_STOP : TH_BYTE;
            sh_d  = 8'hFF;
          end else begin
            st_d   = TH_BYTE;
            step_d = 2'h0;
            sh_d   = {`TWE_DEV_PATTERN, sel_q, 1'b0};
          end
        end
      end
      TH_BYTE: begin
        oe_d = (bit_q != `TWE_ACK_BIT) && !sh_q[7];
        if (tick_w && ph_q == 2'h2 && bit_q == `TWE_ACK_BIT) begin
          nack_d = sda_sy_q[1];
        end
        if (end_w && bit_q != `TWE_ACK_BIT) begin
          bit_d = 4'(bit_q + 4'h1);
          sh_d  = {sh_q[6:0], 1'b1};
        end else if (end_w) begin
          bit_d = 4'h0;
          if (op_q == TOP_RECOVER) begin
            st_d = TH_START;
          end else if (nack_q) begin
            ok_d = 1'b0;
            st_d = TH_STOP;
          end else begin
            unique case (step_q)
              2'h0: begin
                st_d   = (op_q == TOP_POLL) ? TH_STOP : TH_BYTE;
                sh_d   = {1'b0, addr_q[14:8]};
                step_d = 2'h1;
              end
              2'h1: begin
                sh_d   = addr_q[7:0];
                step_d = 2'h2;
              end
              default: begin
                st_d = last_q ? TH_STOP : TH_FETCH;
              end
            endcase
          end
        end
      end
      TH_FETCH: begin
        // clock parked low while the byte source stalls
        scl_d = 1'b0;
        q_d   = 8'h00;
        ph_d  = 2'h0;
        if (wr_valid) begin
          sh_d   = wr_data;
          last_d = wr_last;
          step_d = 2'h3;
          st_d   = TH_BYTE;
        end
      end
      TH_STOP: begin
        scl_d = (ph_q != 2'h0);
        oe_d  = !ph_q[1];
        if (end_w) begin
          st_d    = TH_IDLE;
          done_d  = 1'b1;
          acked_d = ok_q;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q     <= TH_IDLE;
      op_q     <= TOP_WRITE;
      ph_q     <= 2'h0;
      q_q      <= 8'h00;
      step_q   <= 2'h0;
      sh_q     <= 8'hFF;
      bit_q    <= 4'h0;
      sel_q    <= 3'h0;
      addr_q   <= 15'h0000;
      last_q   <= 1'b0;
      rec_q    <= 1'b0;
      ok_q     <= 1'b0;
      nack_q   <= 1'b1;
      sda_sy_q <= 2'h3;
      scl_q    <= 1'b1;
      oe_q     <= 1'b0;
      done_q   <= 1'b0;
      acked_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      op_q     <= op_d;
      ph_q     <= ph_d;
      q_q      <= q_d;
      step_q   <= step_d;
      sh_q     <= sh_d;
      bit_q    <= bit_d;
      sel_q    <= sel_d;
      addr_q   <= addr_d;
      last_q   <= last_d;
      rec_q    <= rec_d;
      ok_q     <= ok_d;
      nack_q   <= nack_d;
      sda_sy_q <= sda_sy_d;
      scl_q    <= scl_d;
      oe_q     <= oe_d;
      done_q   <= done_d;
      acked_q  <= acked_d;
    end
  end

  assign cmd_ready        = (st_q == TH_IDLE);
  assign wr_ready         = (st_q == TH_FETCH);
  assign done             = done_q;
  assign acked            = acked_q;
  assign link.scl         = scl_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = oe_q;

endmodule : tweep_host

// >>> testbench/tweep_assertions.sv
// concurrent checks on the two-wire link between host and memory target
module tweep_checker #(
  parameter int unsigned PROG_CYCLES = 2000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic busy,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        scl_q;
  logic        sda_q;
  logic        start_seen;
  logic [7:0]  bits_q;
  logic [7:0]  bits_d;
  logic [15:0] busy_q;
  logic [15:0] busy_d;
  //////////////////////////////////////////////////////////////////////////////
  // clock rises counted since the last start, so the ack slot is known
  assign start_seen = scl && scl_q && sda_q && !sda;
  always_comb begin
    bits_d = bits_q;
    if (start_seen) begin
      bits_d = 8'h00;
    end else if (scl && !scl_q) begin
      bits_d = bits_q + 8'h01;
    end
    busy_d = busy ? busy_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk) begin
    scl_q  <= rst_n ? scl : 1'b1;
    sda_q  <= rst_n ? sda : 1'b1;
    bits_q <= rst_n ? bits_d : 8'h00;
    busy_q <= rst_n ? busy_d : 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data changed while clock high");
  chk_ack_pulls_low: assert property (dev_sda_oe |-> !sda)
    else $error("target drive does not pull data low");
  chk_ack_holds_high: assert property ($rose(scl) && dev_sda_oe |-> (dev_sda_oe && scl) [*8])
    else $error("ack released during its clock pulse");
  chk_ack_ninth_bit: assert property ($rose(scl) && dev_sda_oe |-> (bits_q % 8'h09) == 8'h08)
    else $error("ack outside the ninth clock");
  chk_silent_busy: assert property (busy |-> !dev_sda_oe)
    else $error("target answered while programming");
  chk_standby_busy: assert property (busy |-> !standby)
    else $error("standby during programming");
  chk_busy_after_stop: assert property ($rose(busy) |-> scl && sda && !host_sda_oe)
    else $error("programming began on a busy link");
  chk_busy_length: assert property ($fell(busy) |->
      busy_q <= PROG_CYCLES && busy_q + 16'h0002 >= PROG_CYCLES)
    else $error("programming length wrong");
  cover property ($rose(busy));
  cover property ($rose(scl) && dev_sda_oe);
  cover property (start_seen);
endmodule : tweep_checker

// >>> testbench/two_wire_eeprom_slave_write_tb.sv
// self-checking bench: host end driving the memory target end
module two_wire_eeprom_slave_write_tb import tweep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // long enough that a poll right after a write still finds it busy
  localparam int unsigned PROG = 2000;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         cmd_valid = 1'b0;
  tweep_op_type cmd_op = TOP_WRITE;
  logic [2:0]   cmd_sel = 3'h0;
  logic [14:0]  cmd_addr = 15'h0000;
  logic         wr_valid = 1'b0;
  logic [7:0]   wr_data = 8'h00;
  logic         wr_last = 1'b0;
  logic         write_protect = 1'b0;
  logic [2:0]   straps = 3'h5;
  logic [14:0]  peek_addr = 15'h0000;
  logic         cmd_ready, wr_ready, done, acked, busy, standby, ack;
  logic [7:0]   peek_data;
  logic [7:0]   wbuf [0:3];
  int           miscompares = 0;
  int           checks = 0;
  tweep_if link ();
  tweep_host i_tweep_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last),
    .done(done), .acked(acked));
  tweep_target #(.PROG_CYCLES(PROG)) i_tweep_target (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .chip_select_straps(straps), .write_protect(write_protect),
    .peek_addr(peek_addr), .peek_data(peek_data), .busy(busy), .standby(standby));
  tweep_checker #(.PROG_CYCLES(PROG)) i_tweep_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl(link.scl), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .sda(link.sda), .busy(busy), .standby(standby));
  always #50 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  // ready is judged at the falling edge, the handshake lands on the next rise
  // which: 0 command ready, 1 data ready, 2 done
  task automatic wait_hi(input int which);
    @(negedge ref_clk);
    while ((which == 0 ? cmd_ready : (which == 1 ? wr_ready : done)) !== 1'b1) begin
      @(negedge ref_clk);
    end
  endtask : wait_hi
  task automatic issue(input tweep_op_type op, input logic [2:0] sel, input logic [14:0] addr,
                       input int n);
    @(posedge ref_clk);
    cmd_op <= op;
    cmd_sel <= sel;
    cmd_addr <= addr;
    cmd_valid <= 1'b1;
    wait_hi(0);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    wr_valid <= (n > 0);
    for (int i = 0; i < n; i++) begin
      wr_data <= wbuf[i];
      wr_last <= (i == n - 1);
      wait_hi(1);
      @(posedge ref_clk);
    end
    wr_valid <= 1'b0;
    wait_hi(2);
    ack = acked;
  endtask : issue
  // bounded wait: a programming cycle that never ends shows up as a mismatch
  task automatic settle;
    repeat (20) @(negedge ref_clk);
    for (int n = 0; n < PROG + 100 && busy !== 1'b0; n++) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    cmp_bit(busy, 1'b0);
    cmp_bit(standby, 1'b1);
  endtask : settle
  task automatic check_mem(input logic [14:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    peek_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_byte(peek_data, exp);
  endtask : check_mem
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_page_wrap;
    logic [14:0] base;
    base = 15'h0A3E;
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
    issue(TOP_WRITE, 3'h5, base, 3);
    cmp_bit(ack, 1'b1);
    issue(TOP_POLL, 3'h5, 15'h0000, 0);
    cmp_bit(ack, 1'b0);
    cmp_bit(busy, 1'b1);
    for (int k = 0; k < 8 && ack !== 1'b1; k++) begin
      issue(TOP_POLL, 3'h5, 15'h0000, 0);
    end
    cmp_bit(ack, 1'b1);
    settle();
    for (int i = 0; i < 3; i++) begin
      check_mem({base[14:6], base[5:0] + 6'(i)}, wbuf[i]);
    end
  endtask : t_page_wrap
  task automatic t_select;
    issue(TOP_POLL, 3'h2, 15'h0000, 0);
    cmp_bit(ack, 1'b0);
    cmp_bit(standby, 1'b1);
    @(posedge ref_clk);
    straps <= 3'h2;
    issue(TOP_POLL, 3'h2, 15'h0000, 0);
    cmp_bit(ack, 1'b1);
    @(posedge ref_clk);
    straps <= 3'h5;
    issue(TOP_POLL, 3'h5, 15'h0000, 0);
    cmp_bit(ack, 1'b1);
  endtask : t_select
  task automatic t_protect;
    @(posedge ref_clk);
    write_protect <= 1'b1;
    wbuf[0] = 8'h5A;
    issue(TOP_WRITE, 3'h5, 15'h0A3E, 1);
    cmp_bit(ack, 1'b1);
    settle();
    check_mem(15'h0A3E, 8'h11);
    @(posedge ref_clk);
    write_protect <= 1'b0;
  endtask : t_protect
  task automatic t_recover;
    issue(TOP_RECOVER, 3'h5, 15'h0000, 0);
    wbuf[0] = 8'hC3;
    issue(TOP_WRITE, 3'h5, 15'h0105, 1);
    cmp_bit(ack, 1'b1);
    settle();
    check_mem(15'h0105, 8'hC3);
  endtask : t_recover
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(negedge ref_clk);
    cmp_bit(standby, 1'b1);
    cmp_bit(busy, 1'b0);
    t_page_wrap();
    t_select();
    t_protect();
    t_recover();
    complete_run();
  end
  // whole sequence needs roughly a third of this span
  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule : two_wire_eeprom_slave_write_tb
